//--- inc/pmc_pkg.sv
/*
 * Constants, field layout and carrier types of the power-management
 * capability block. Assumes a dword-wide configuration access port
 * whose byte address is dword aligned.
 */
package pmc_pkg;

    // Configuration dword offsets
    localparam logic [7:0] PMC_CAP_DW_OFS = 8'ha0;
    localparam logic [7:0] PMC_CSR_DW_OFS = 8'ha4;

    // Capability list header bytes
    localparam logic [7:0] PMC_CAP_ID = 8'h01;
    localparam logic [7:0] PMC_NEXT_PTR = 8'h00;

    // Power capabilities word fields
    localparam int PMC_CAP_D3C_WAKE_BIT = 15;
    localparam logic [3:0] PMC_CAP_WAKE_FIXED = 4'hf;
    localparam logic PMC_CAP_D2_SUPPORT = 1'b1;
    localparam logic PMC_CAP_D1_STATE_SUPPORTED = 1'b1;
    localparam logic [2:0] PMC_CAP_RSVD = 3'h0;
    localparam logic PMC_CAP_DEV_INIT = 1'b0;
    localparam logic [2:0] PMC_CAP_REVISION = 3'h2;
    localparam logic PMC_CAP_D3C_WAKE_RST = 1'b1;

    // Control/status word fields
    localparam int PMC_CSR_WAKE_STAT_BIT = 15;
    localparam int PMC_CSR_WAKE_EN_BIT = 8;
    localparam logic [1:0] PMC_CSR_SCALE = 2'h0;
    localparam logic [3:0] PMC_CSR_SELECT = 4'h0;
    localparam logic [5:0] PMC_CSR_RSVD = 6'h0;
    localparam logic [15:0] PMC_CSR_RST = 16'h0000;

    // Byte lanes inside the configuration dwords
    localparam int PMC_LANE_CAP_LO = 2;
    localparam int PMC_LANE_CAP_HI = 3;
    localparam int PMC_LANE_CSR_LO = 0;
    localparam int PMC_LANE_CSR_HI = 1;

    // Internal function reset pulse length, in clock cycles
    localparam int PMC_FRST_CYCLES = 4;

    typedef enum logic [1:0] {
        PMC_D0 = 2'h0,
        PMC_D1 = 2'h1,
        PMC_D2 = 2'h2,
        PMC_D3HOT = 2'h3
    } pmc_pstate_e;

    typedef struct packed {
        logic req;
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pmc_cfg_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } pmc_cfg_rsp_s;

endpackage

//--- logic/pmc_power_cap.sv
/*
 * Power-management capability and control/status registers of a
 * card-bridge function, reached through its configuration access port.
 * Assumes config requests and wake events come from logic on clk; the
 * global and bus reset pins are asynchronous active-low levels.
 */
`timescale 1ns/100ps
module pmc_power_cap
    import pmc_pkg::*;
#(
    parameter logic AUX_SUPPLY_NEEDED = 1'b1,
    parameter logic WAKE_NEEDS_BUS_CLOCK = 1'b0,
    parameter int FRST_LEN = PMC_FRST_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic global_reset_in_n,
    input wire logic bus_reset_in_n,
    input wire pmc_cfg_req_s cfg_req,
    output pmc_cfg_rsp_s cfg_rsp,
    input wire logic wake_event_in,
    output logic wake_req_out,
    output logic wake_req_oe,
    output logic [1:0] power_state_field,
    output logic func_reset_out,
    output logic wake_ctx_keep
);

    localparam int FRST_W = $clog2(FRST_LEN + 1);

    typedef struct packed {
        logic d3c_wake;
        pmc_pstate_e pstate;
        logic wake_en;
        pmc_cfg_rsp_s rsp;
        logic [FRST_W-1:0] frst_cnt;
        logic frst;
        logic ctx_keep;
        logic wake_oe;
    } pmc_top_s;

    pmc_top_s st_q;
    pmc_top_s st_d;

    logic glb_rst_n_s;
    logic bus_rst_n_s;
    logic glb_clr;
    logic bus_clr;
    logic wake_stat;
    logic hit_cap;
    logic hit_csr;
    logic wr_cap_hi;
    logic wr_csr_lo;
    logic wr_csr_hi;
    logic stat_clr_wr;
    logic [15:0] cap_word;
    logic [15:0] csr_word;

    generate
        if (FRST_LEN < 1) begin : g_chk
            $error("pmc_power_cap: FRST_LEN must be at least 1");
        end
    endgenerate

    function automatic logic lane_wr(input pmc_cfg_req_s r,
                                     input logic hit, input int lane);
        lane_wr = r.req && r.wr && hit && r.be[lane];
    endfunction

    pmc_sync #(
        .WIDTH(2),
        .RST_VAL(2'h3)
    ) u_rst_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in({global_reset_in_n, bus_reset_in_n}),
        .level_out({glb_rst_n_s, bus_rst_n_s})
    );

    assign glb_clr = !glb_rst_n_s;
    assign bus_clr = !bus_rst_n_s;

    // Address decode
    always_comb begin
        hit_cap = 1'b0;
        hit_csr = 1'b0;
        if (cfg_req.addr == PMC_CAP_DW_OFS) begin
            hit_cap = 1'b1;
        end else if (cfg_req.addr == PMC_CSR_DW_OFS) begin
            hit_csr = 1'b1;
        end
    end

    assign wr_cap_hi = lane_wr(cfg_req, hit_cap, PMC_LANE_CAP_HI);
    assign wr_csr_lo = lane_wr(cfg_req, hit_csr, PMC_LANE_CSR_LO);
    assign wr_csr_hi = lane_wr(cfg_req, hit_csr, PMC_LANE_CSR_HI);
    assign stat_clr_wr = wr_csr_hi && cfg_req.wdata[8 + 7];

    pmc_wake u_wake (
        .clk(clk),
        .sys_rst(sys_rst),
        .glb_clr(glb_clr),
        .wake_event(wake_event_in),
        .clear_wr(stat_clr_wr),
        .wake_event_status(wake_stat)
    );

    // Capabilities word assembly
    always_comb begin
        logic any_wake;
        any_wake = st_q.d3c_wake || (|PMC_CAP_WAKE_FIXED);
        cap_word[PMC_CAP_D3C_WAKE_BIT] = st_q.d3c_wake;
        cap_word[14:11] = PMC_CAP_WAKE_FIXED;
        cap_word[10] = PMC_CAP_D2_SUPPORT;
        cap_word[9] = PMC_CAP_D1_STATE_SUPPORTED;
        cap_word[8:6] = PMC_CAP_RSVD;
        cap_word[5] = PMC_CAP_DEV_INIT;
        cap_word[4] = AUX_SUPPLY_NEEDED && st_q.d3c_wake;
        cap_word[3] = WAKE_NEEDS_BUS_CLOCK && any_wake;
        cap_word[2:0] = PMC_CAP_REVISION;
    end

    // Control/status word assembly
    always_comb begin
        csr_word[PMC_CSR_WAKE_STAT_BIT] = wake_stat;
        csr_word[14:13] = PMC_CSR_SCALE;
        csr_word[12:9] = PMC_CSR_SELECT;
        csr_word[PMC_CSR_WAKE_EN_BIT] = st_q.wake_en;
        csr_word[7:2] = PMC_CSR_RSVD;
        csr_word[1:0] = st_q.pstate;
    end

    always_comb begin
        pmc_pstate_e new_ps;
        new_ps = pmc_pstate_e'(cfg_req.wdata[1:0]);
        st_d = st_q;

        // Configuration answer, one cycle after the request
        st_d.rsp.ack = cfg_req.req;
        st_d.rsp.rdata = '0;
        if (cfg_req.req && !cfg_req.wr) begin
            if (hit_cap) begin
                st_d.rsp.rdata = {cap_word, PMC_NEXT_PTR, PMC_CAP_ID};
            end else if (hit_csr) begin
                st_d.rsp.rdata = {16'h0000, csr_word};
            end
        end

        if (wr_cap_hi) begin
            st_d.d3c_wake = cfg_req.wdata[16 + PMC_CAP_D3C_WAKE_BIT];
        end

        if (wr_csr_hi) begin
            st_d.wake_en = cfg_req.wdata[PMC_CSR_WAKE_EN_BIT];
        end

        // Function reset pulse countdown
        if (st_q.frst_cnt != '0) begin
            st_d.frst_cnt = st_q.frst_cnt - 1'b1;
        end
        st_d.frst = (st_d.frst_cnt != '0);

        if (wr_csr_lo) begin
            st_d.pstate = new_ps;
            case (st_q.pstate)
                PMC_D3HOT: begin
                    if (new_ps == PMC_D0) begin
                        st_d.frst_cnt = FRST_W'(FRST_LEN);
                        st_d.frst = 1'b1;
                        st_d.ctx_keep = st_q.wake_en;
                    end
                end
                default: begin
                end
            endcase
        end
        if (!st_d.frst) begin
            st_d.ctx_keep = 1'b0;
        end
        // Control/status word is not touched by frst

        // Drive request from status and enable
        // Never driven when disabled
        // Uses the next enable so a write that clears the enable bit drops the pin at once
        st_d.wake_oe = wake_stat && st_d.wake_en && !stat_clr_wr
                       && !glb_clr;

        // Bus reset spares wake enable, wake status and D3cold support; it clears the wake context flag
        if (bus_clr) begin
            st_d.pstate = PMC_D0;
            st_d.frst_cnt = '0;
            st_d.frst = 1'b0;
            st_d.ctx_keep = 1'b0;
        end

        // Of the two reset pins, only global reset clears wake enable
        if (glb_clr) begin
            st_d.d3c_wake = PMC_CAP_D3C_WAKE_RST;
            st_d.pstate = pmc_pstate_e'(PMC_CSR_RST[1:0]);
            st_d.wake_en = PMC_CSR_RST[PMC_CSR_WAKE_EN_BIT];
            st_d.frst_cnt = '0;
            st_d.frst = 1'b0;
            st_d.ctx_keep = 1'b0;
            st_d.wake_oe = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
            st_q.d3c_wake <= PMC_CAP_D3C_WAKE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign cfg_rsp = st_q.rsp;
    assign wake_req_out = 1'b0;
    assign wake_req_oe = st_q.wake_oe;
    assign power_state_field = st_q.pstate;
    assign func_reset_out = st_q.frst;
    assign wake_ctx_keep = st_q.ctx_keep;

endmodule

//--- logic/pmc_sync.sv
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes levels from outside the clock domain; RST_VAL is the idle level.
 */
`timescale 1ns/100ps
module pmc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } pmc_sync_s;

    pmc_sync_s st_q;
    pmc_sync_s st_d;

    generate
        if (WIDTH < 1) begin : g_chk
            $error("pmc_sync: WIDTH must be at least 1");
        end
    endgenerate

    always_comb begin
        st_d.meta = pin_in;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= {RST_VAL, RST_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign level_out = st_q.stable;

endmodule

//--- logic/pmc_wake.sv
/*
 * Sticky wake status flag: set by a wake event, cleared by a write of one.
 * Assumes event and clear strobes are single-cycle, on the same clock.
 */
`timescale 1ns/100ps
module pmc_wake (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic glb_clr,
    input wire logic wake_event,
    input wire logic clear_wr,
    output logic wake_event_status
);

    typedef struct packed {
        logic stat;
    } pmc_wake_s;

    pmc_wake_s st_q;
    pmc_wake_s st_d;

    always_comb begin
        st_d = st_q;
        if (glb_clr) begin
            st_d.stat = 1'b0;
        end else if (wake_event) begin
            st_d.stat = 1'b1;
        end else if (clear_wr) begin
            st_d.stat = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign wake_event_status = st_q.stat;

endmodule

//--- verif/pmc_host.sv
/* Configuration host model: one strobe per access.
   Assumes the access port answers with ack on clk. */
`timescale 1ns/100ps
module pmc_host
    import pmc_pkg::*;
(
    input wire logic clk,
    output pmc_cfg_req_s cfg_req,
    input wire pmc_cfg_rsp_s cfg_rsp
);
    int gap = 0;
    initial cfg_req = '0;
    task automatic access(input logic wr, input logic [7:0] addr,
        input logic [3:0] be, input logic [31:0] wd,
        output logic [31:0] rd);
        int n;
        n = 0;
        repeat (gap) @(posedge clk);
        cfg_req <= '{req: 1'b1, wr: wr, addr: addr, be: be, wdata: wd};
        @(posedge clk);
        cfg_req.req <= 1'b0;
        // Released lines carry junk
        cfg_req.addr <= ~addr;
        cfg_req.wdata <= ~wd;
        @(posedge clk);
        while (cfg_rsp.ack !== 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        rd = (cfg_rsp.ack === 1'b1) ? cfg_rsp.rdata : 'x;
    endtask
endmodule

//--- verif/pmc_power_cap_sva.sv
/* Assertions on the ports of the capability block.
   Bound into pmc_power_cap; one clock, reset sys_rst. */
`timescale 1ns/100ps
module pmc_power_cap_sva
    import pmc_pkg::*;
#(
    parameter logic AUX_SUPPLY_NEEDED = 1'b1,
    parameter logic WAKE_NEEDS_BUS_CLOCK = 1'b0,
    parameter int FRST_LEN = PMC_FRST_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic global_reset_in_n,
    input wire logic bus_reset_in_n,
    input wire pmc_cfg_req_s cfg_req,
    input wire pmc_cfg_rsp_s cfg_rsp,
    input wire logic wake_event_in,
    input wire logic wake_req_out,
    input wire logic wake_req_oe,
    input wire logic [1:0] power_state_field,
    input wire logic func_reset_out,
    input wire logic wake_ctx_keep
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic rd_cap, rd_csr, wr_csr;
    int run_q;
    assign rd_cap = cfg_req.req && !cfg_req.wr
                    && cfg_req.addr == PMC_CAP_DW_OFS;
    assign rd_csr = cfg_req.req && !cfg_req.wr
                    && cfg_req.addr == PMC_CSR_DW_OFS;
    assign wr_csr = cfg_req.req && cfg_req.wr
                    && cfg_req.addr == PMC_CSR_DW_OFS;
    // Length of the current function reset run
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            run_q <= 0;
        else
            run_q <= func_reset_out ? run_q + 1 : 0;
    end
    cap_fixed_bits_a: assert property (rd_cap |=>
        cfg_rsp.rdata[25:21] == 5'h10 && cfg_rsp.rdata[18:16] == 3'h2)
        else $error("fixed capability bits wrong");
    aux_bit_a: assert property (rd_cap |=>
        cfg_rsp.rdata[20] == (AUX_SUPPLY_NEEDED && cfg_rsp.rdata[31]))
        else $error("aux supply bit wrong");
    clock_need_a: assert property (rd_cap |=>
        cfg_rsp.rdata[19] == WAKE_NEEDS_BUS_CLOCK)
        else $error("bus clock need bit wrong");
    csr_zero_a: assert property (rd_csr |=>
        cfg_rsp.rdata[31:16] == 16'h0 && cfg_rsp.rdata[14:9] == 6'h0
        && cfg_rsp.rdata[7:2] == 6'h0) else $error("csr zero fields set");
    state_read_a: assert property (rd_csr |=>
        cfg_rsp.rdata[1:0] == $past(power_state_field))
        else $error("power state readback wrong");
    state_write_a: assert property (wr_csr && cfg_req.be[0] |=>
        power_state_field == $past(cfg_req.wdata[1:0]))
        else $error("power state not written");
    wake_clear_a: assert property (wr_csr && cfg_req.be[1]
        && cfg_req.wdata[15] && !wake_event_in |=> !wake_req_oe)
        else $error("wake request not released");
    zero_write_a: assert property (wr_csr && cfg_req.be[1]
        && cfg_req.wdata[8] && !cfg_req.wdata[15] && wake_req_oe
        |=> wake_req_oe) else $error("zero write dropped wake");
    frst_start_a: assert property (wr_csr && cfg_req.be[0]
        && cfg_req.wdata[1:0] == 2'h0 && power_state_field == 2'h3
        |=> func_reset_out) else $error("no function reset");
    frst_len_a: assert property ($fell(func_reset_out) |->
        run_q == FRST_LEN) else $error("function reset length wrong");
    ctx_hold_a: assert property (func_reset_out && $past(func_reset_out)
        |-> $stable(wake_ctx_keep)) else $error("wake context flag moved");
    pin_data_a: assert property (wake_req_oe |-> !wake_req_out)
        else $error("wake pin not pulled low");
    wake_rise_a: assert property ($rose(wake_req_oe) |->
        $past(wake_event_in, 2)
        || $past(wr_csr && cfg_req.be[1] && cfg_req.wdata[8]))
        else $error("wake request raised without cause");
    wake_off_a: assert property (wr_csr && cfg_req.be[1]
        && !cfg_req.wdata[8] |=> !wake_req_oe)
        else $error("wake request driven while disabled");
endmodule

bind pmc_power_cap pmc_power_cap_sva #(
    .AUX_SUPPLY_NEEDED(AUX_SUPPLY_NEEDED),
    .WAKE_NEEDS_BUS_CLOCK(WAKE_NEEDS_BUS_CLOCK),
    .FRST_LEN(FRST_LEN)
) i_sva (
    .clk(clk),
    .sys_rst(sys_rst),
    .global_reset_in_n(global_reset_in_n),
    .bus_reset_in_n(bus_reset_in_n),
    .cfg_req(cfg_req),
    .cfg_rsp(cfg_rsp),
    .wake_event_in(wake_event_in),
    .wake_req_out(wake_req_out),
    .wake_req_oe(wake_req_oe),
    .power_state_field(power_state_field),
    .func_reset_out(func_reset_out),
    .wake_ctx_keep(wake_ctx_keep)
);

//--- verif/tb.sv
/* Self-checking bench of the capability block.
   Default parameters; host model drives the access port. */
`timescale 1ns/100ps
module tb
    import pmc_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic global_reset_in_n = 1'b1;
    logic bus_reset_in_n = 1'b1;
    logic wake_event_in = 1'b0;
    pmc_cfg_req_s cfg_req;
    pmc_cfg_rsp_s cfg_rsp;
    logic wake_req_out, wake_req_oe, func_reset_out, wake_ctx_keep;
    logic [1:0] power_state_field;
    logic keep_cap = 1'b0;
    int failures = 0;
    int total_checks = 0;
    int cyc = 0;
    int frst_cnt = 0;
    // Open-drain pin with pull-up
    wire wake_n = wake_req_oe ? wake_req_out : 1'b1;
    always #2.5 clk = ~clk;
    pmc_power_cap i_dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .global_reset_in_n(global_reset_in_n),
        .bus_reset_in_n(bus_reset_in_n),
        .cfg_req(cfg_req),
        .cfg_rsp(cfg_rsp),
        .wake_event_in(wake_event_in),
        .wake_req_out(wake_req_out),
        .wake_req_oe(wake_req_oe),
        .power_state_field(power_state_field),
        .func_reset_out(func_reset_out),
        .wake_ctx_keep(wake_ctx_keep)
    );
    pmc_host i_host (.clk(clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));
    task automatic report_and_stop;
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] d);
        logic [31:0] junk;
        i_host.access(1'b1, a, be, d, junk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] got;
        i_host.access(1'b0, a, 4'h0, 32'h0, got);
        chk(got, exp);
    endtask
    task automatic wake_pulse;
        wake_event_in <= 1'b1;
        @(posedge clk);
        wake_event_in <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // Function reset tally and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (func_reset_out === 1'b1) begin
            frst_cnt <= frst_cnt + 1;
            keep_cap <= wake_ctx_keep;
        end
        if (cyc == 3000) begin
            failures++;
            report_and_stop;
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        rd_chk(PMC_CAP_DW_OFS, 32'hfe12_0001);
        rd_chk(PMC_CSR_DW_OFS, 32'h0);
        wr(PMC_CAP_DW_OFS, 4'h8, 32'h0);
        rd_chk(PMC_CAP_DW_OFS, 32'h7e02_0001);
        wr(PMC_CAP_DW_OFS, 4'hf, 32'hffff_ffff);
        rd_chk(PMC_CAP_DW_OFS, 32'hfe12_0001);
        wr(8'ha8, 4'hf, 32'hffff_ffff);
        rd_chk(8'ha8, 32'h0);
        for (int s = 3; s >= 0; s--) begin
            wr(PMC_CSR_DW_OFS, 4'h1, 32'(s));
            rd_chk(PMC_CSR_DW_OFS, 32'(s));
        end
        wr(PMC_CSR_DW_OFS, 4'h3, 32'hffff_7ffd);
        rd_chk(PMC_CSR_DW_OFS, 32'h0101);
        wake_pulse;
        chk({31'h0, wake_n}, 32'h0);
        wr(PMC_CSR_DW_OFS, 4'h3, 32'h0101);
        chk({31'h0, wake_n}, 32'h0);
        rd_chk(PMC_CSR_DW_OFS, 32'h8101);
        wr(PMC_CSR_DW_OFS, 4'h3, 32'h8101);
        chk({31'h0, wake_n}, 32'h1);
        rd_chk(PMC_CSR_DW_OFS, 32'h0101);
        wr(PMC_CSR_DW_OFS, 4'h3, 32'h0001);
        wake_pulse;
        chk({31'h0, wake_n}, 32'h1);
        rd_chk(PMC_CSR_DW_OFS, 32'h8001);
        wr(PMC_CSR_DW_OFS, 4'h3, 32'h0102);
        repeat (2) @(posedge clk);
        chk({31'h0, wake_n}, 32'h0);
        wr(PMC_CSR_DW_OFS, 4'h2, 32'h0000);
        chk({31'h0, wake_n}, 32'h1);
        wr(PMC_CSR_DW_OFS, 4'h2, 32'h0100);
        repeat (2) @(posedge clk);
        chk({31'h0, wake_n}, 32'h0);
        i_host.gap = 3;
        bus_reset_in_n <= 1'b0;
        repeat (4) @(posedge clk);
        bus_reset_in_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(PMC_CSR_DW_OFS, 32'h8100);
        wr(PMC_CSR_DW_OFS, 4'h1, 32'h3);
        wr(PMC_CSR_DW_OFS, 4'h1, 32'h0);
        repeat (8) @(posedge clk);
        chk(32'(frst_cnt), 32'(PMC_FRST_CYCLES));
        chk({31'h0, keep_cap}, 32'h1);
        rd_chk(PMC_CSR_DW_OFS, 32'h8100);
        global_reset_in_n <= 1'b0;
        repeat (4) @(posedge clk);
        global_reset_in_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(PMC_CSR_DW_OFS, 32'h0);
        wr(PMC_CSR_DW_OFS, 4'h1, 32'h3);
        wr(PMC_CSR_DW_OFS, 4'h1, 32'h0);
        repeat (8) @(posedge clk);
        chk(32'(frst_cnt), 32'(2 * PMC_FRST_CYCLES));
        chk({31'h0, keep_cap}, 32'h0);
        report_and_stop;
    end
endmodule
